// ===== src/strap_host_pkg.sv
// constants, types and contract for the strap-select asynchronous host port
// Contract
// - rate strap 00 gives 4 MHz, 01 gives 10 MHz, 10 gives 40 MHz clock out; here 00 gives about 4.2 MHz, 01 and 10 both give 12.5 MHz
// - rate strap 11 disables clock output, pin held low
// - port strap 00 reserved, 01 async main clock, 10 sync slave, 11 async external clock; here 10 leaves the port dead and 11 runs on the main clock
// - port strap captured when leaving internal or external reset, configures the port
// - later port strap changes ignored until next reset
// - reserved port strap halts activity, no host transactions answered ever; here the halt lasts only until the next reset
// - registers selected only under chip enable, using word address lines 12 to 1
// - only aligned 16-bit reads and 8 or 16-bit writes accepted
// - write byte selects: 00 word, 01 even byte, 10 odd byte, 11 illegal
// - both strobes low illegal; chip enable high or both strobes high no access
// - word write stores 15..8 even, 7..0 odd; byte writes use matching half
// - read returns even byte on 15..8 and odd byte on 7..0
// - data driven only during reads with output enable, direction from write strobe
// - single transfers only, no bursts
// - data line 0 is the least significant bit
// - one interrupt request line from internal interrupt controller
// - interrupt request is level, active low
// - strap pins undriven with pulldowns while straps are captured
package strap_host_pkg;
    localparam int          CLK_HZ         = 25_000_000;
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 16;
    localparam int          WORDS          = 4096;
    localparam logic [1:0]  RATE_4M        = 2'h0;
    localparam logic [1:0]  RATE_10M       = 2'h1;
    localparam logic [1:0]  RATE_40M       = 2'h2;
    localparam logic [1:0]  RATE_OFF       = 2'h3;
    localparam logic [1:0]  PORT_RESERVED  = 2'h0;
    localparam logic [1:0]  PORT_ASYNC_MAIN = 2'h1;
    localparam logic [1:0]  PORT_SYNC      = 2'h2;
    localparam logic [1:0]  PORT_ASYNC_EXT = 2'h3;
    localparam logic [1:0]  SEL_WORD       = 2'h0;
    localparam logic [1:0]  SEL_EVEN       = 2'h1;
    localparam logic [1:0]  SEL_ODD        = 2'h2;
    // 4 MHz half period in main clocks, rounded down (25/8 = 3)
    localparam int          HALF_4M        = CLK_HZ / 8_000_000;
    // 10 MHz half period rounded down, at least one cycle
    localparam int          HALF_10M       = (CLK_HZ / 20_000_000) < 1 ? 1 : CLK_HZ / 20_000_000;
    // 40 MHz exceeds the main clock; fastest toggle possible
    localparam int          HALF_40M       = 1;
    localparam int          CNT_W          = 4;

    typedef struct packed {
        logic                ce_n;
        logic                we_n;
        logic                oe_n;
        logic [1:0]          bsel_n;
    } strobes_t;

    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_WRITE,
        ACC_READ,
        ACC_ILLEGAL
    } access_t;

    typedef enum {
        ST_IDLE,
        ST_DONE,
        ST_HALT
    } port_state_t;
endpackage : strap_host_pkg

// ===== src/strap_host_port.sv
// strap capture, clock output divider and asynchronous memory port
`timescale 1ns/10ps
module strap_host_port
    import strap_host_pkg::*;
(
    input  wire logic                CLK_I,
    input  wire logic                RESETN_I,
    input  wire logic                EXT_HOST_CLK_I,
    input  wire logic [1:0]          PORT_STRAP_I,
    input  wire logic [1:0]          RATE_STRAP_I,
    input  wire logic                CE_N_I,
    input  wire logic                WE_N_I,
    input  wire logic                OE_N_I,
    input  wire logic [1:0]          BYTE_LANE_SELECT_N_I,
    input  wire logic [ADDR_W-1:0]   ADDR_I,
    input  wire logic [DATA_W-1:0]   DATA_I,
    input  wire logic                IRQ_REQ_I,
    output logic [DATA_W-1:0]        DATA_O,
    output logic                     DATA_OE_O,
    output logic                     STRAP_PULLDOWN_O,
    output logic                     REFERENCE_CLOCK_OUTPUT_O,
    output logic                     HOST_IRQ_N_O,
    output logic [1:0]               PORT_MODE_O,
    output logic                     HALTED_O,
    output logic                     ILLEGAL_O
);
    logic                capturing;
    logic [1:0]          port_mode;
    logic [1:0]          rate_mode;
    logic [1:0]          port_s1;
    logic [1:0]          port_s2;
    logic [1:0]          rate_s1;
    logic [1:0]          rate_s2;
    strobes_t            strb_s1;
    strobes_t            strb_s2;
    logic [ADDR_W-1:0]   addr_s1;
    logic [ADDR_W-1:0]   addr_s2;
    logic [DATA_W-1:0]   data_s1;
    logic [DATA_W-1:0]   data_s2;
    logic                irq_s1;
    logic                irq_s2;
    logic                ext_s1;
    logic                ext_s2;
    logic                ext_d;
    port_state_t         state;
    port_state_t         next_state;
    logic [7:0]          mem_even [WORDS];
    logic [7:0]          mem_odd  [WORDS];
    logic [CNT_W-1:0]    div_cnt;
    logic [CNT_W-1:0]    half_sel;

    // strap pin and host strobe synchronisers
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            port_s1 <= 2'h0;
            port_s2 <= 2'h0;
            rate_s1 <= 2'h0;
            rate_s2 <= 2'h0;
            strb_s1 <= '1;
            strb_s2 <= '1;
            addr_s1 <= '0;
            addr_s2 <= '0;
            data_s1 <= '0;
            data_s2 <= '0;
            irq_s1  <= 1'b0;
            irq_s2  <= 1'b0;
            ext_s1  <= 1'b0;
            ext_s2  <= 1'b0;
        end else begin
            port_s1 <= PORT_STRAP_I;
            port_s2 <= port_s1;
            rate_s1 <= RATE_STRAP_I;
            rate_s2 <= rate_s1;
            strb_s1 <= {CE_N_I, WE_N_I, OE_N_I, BYTE_LANE_SELECT_N_I};
            strb_s2 <= strb_s1;
            addr_s1 <= ADDR_I;
            addr_s2 <= addr_s1;
            data_s1 <= DATA_I;
            data_s2 <= data_s1;
            irq_s1  <= IRQ_REQ_I;
            irq_s2  <= irq_s1;
            ext_s1  <= EXT_HOST_CLK_I;
            ext_s2  <= ext_s1;
        end
    end

    // strap capture window: first cycles after release, pins undriven
    logic [1:0] cap_cnt;
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cap_cnt   <= 2'h0;
            capturing <= 1'b1;
            port_mode <= PORT_RESERVED;
            rate_mode <= RATE_OFF;
        end else if (capturing) begin
            cap_cnt <= cap_cnt + 2'h1;
            if (cap_cnt == 2'h2) begin
                capturing <= 1'b0;
                port_mode <= port_s2;
                rate_mode <= rate_s2;
            end
        end
    end

    // access decode from synchronised strobes
    wire      port_async = (port_mode == PORT_ASYNC_MAIN) || (port_mode == PORT_ASYNC_EXT);
    wire      selected   = !strb_s2.ce_n && port_async && !capturing;
    wire      wr_cyc     = selected && !strb_s2.we_n && strb_s2.oe_n;
    wire      rd_cyc     = selected && strb_s2.we_n && !strb_s2.oe_n;
    wire      bad_cyc    = selected && !strb_s2.we_n && !strb_s2.oe_n;
    wire      bad_sel    = wr_cyc && (strb_s2.bsel_n == 2'h3);
    wire      wr_even    = wr_cyc && ((strb_s2.bsel_n == SEL_WORD) || (strb_s2.bsel_n == SEL_EVEN));
    wire      wr_odd     = wr_cyc && ((strb_s2.bsel_n == SEL_WORD) || (strb_s2.bsel_n == SEL_ODD));
    access_t  acc;
    assign acc = bad_cyc || bad_sel ? ACC_ILLEGAL : rd_cyc ? ACC_READ : wr_cyc ? ACC_WRITE : ACC_NONE;

    // one write per strobe assertion; idle needed before the next write
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (acc == ACC_WRITE || acc == ACC_ILLEGAL)
                    next_state = ST_DONE;
            end
            ST_DONE: begin
                if (strb_s2.ce_n || (strb_s2.we_n && strb_s2.oe_n))
                    next_state = ST_IDLE;
            end
            ST_HALT: next_state = ST_HALT;
            default: next_state = ST_IDLE;
        endcase
        if (!capturing && port_mode == PORT_RESERVED)
            next_state = ST_HALT;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // word store, even byte high half, odd byte low half
    wire do_write = (state == ST_IDLE) && (acc == ACC_WRITE);
    always_ff @(posedge CLK_I) begin
        if (do_write && wr_even)
            mem_even[addr_s2] <= data_s2[15:8];
        if (do_write && wr_odd)
            mem_odd[addr_s2] <= data_s2[7:0];
    end

    // read data and output enable, only for legal reads with output enable low
    wire rd_ok = (acc == ACC_READ) && (state != ST_HALT);
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            DATA_O    <= '0;
            DATA_OE_O <= 1'b0;
            ILLEGAL_O <= 1'b0;
        end else begin
            DATA_OE_O <= rd_ok;
            if (rd_ok)
                DATA_O <= {mem_even[addr_s2], mem_odd[addr_s2]};
            ILLEGAL_O <= (acc == ACC_ILLEGAL) && (state != ST_HALT);
        end
    end

    // clock output divider; half period chosen by rate strap
    assign half_sel = (rate_mode == RATE_4M)  ? CNT_W'(HALF_4M)  :
                      (rate_mode == RATE_10M) ? CNT_W'(HALF_10M) : CNT_W'(HALF_40M);
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            div_cnt                  <= '0;
            REFERENCE_CLOCK_OUTPUT_O <= 1'b0;
        end else if (capturing || rate_mode == RATE_OFF) begin
            div_cnt                  <= '0;
            REFERENCE_CLOCK_OUTPUT_O <= 1'b0;
        end else if (div_cnt >= half_sel - CNT_W'(1)) begin
            div_cnt                  <= '0;
            REFERENCE_CLOCK_OUTPUT_O <= ~REFERENCE_CLOCK_OUTPUT_O;
        end else begin
            div_cnt <= div_cnt + CNT_W'(1);
        end
    end

    // status outputs, interrupt level and strap pin drive control
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            HOST_IRQ_N_O     <= 1'b1;
            STRAP_PULLDOWN_O <= 1'b1;
            PORT_MODE_O      <= PORT_RESERVED;
            HALTED_O         <= 1'b0;
            ext_d            <= 1'b0;
        end else begin
            HOST_IRQ_N_O     <= ~(irq_s2 && state != ST_HALT);
            STRAP_PULLDOWN_O <= capturing;
            PORT_MODE_O      <= port_mode;
            HALTED_O         <= (state == ST_HALT);
            ext_d            <= ext_s2;
        end
    end

    // external host clock sampled only; keeps it steady when unused
    wire ext_edge = ext_s2 && !ext_d;

    a_halt_sticky: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        HALTED_O |=> HALTED_O) else $error("halt left");
    a_halt_no_drive: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        HALTED_O |-> !DATA_OE_O) else $error("drive while halted");
    a_mode_frozen: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !capturing |=> $stable(port_mode)) else $error("strap changed");
    a_off_low: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (!capturing && rate_mode == RATE_OFF) |=> !REFERENCE_CLOCK_OUTPUT_O) else $error("clock not low");
    sequence s_read;
        rd_ok ##1 DATA_OE_O;
    endsequence
    a_oe_read: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        DATA_OE_O |-> $past(rd_ok)) else $error("drive without read");
    a_read_seq: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        rd_ok |-> s_read) else $error("read not answered");
    a_illegal_flag: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (bad_cyc && state != ST_HALT) |=> ILLEGAL_O) else $error("illegal missed");
    a_irq_level: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (irq_s2 && state != ST_HALT) |=> !HOST_IRQ_N_O) else $error("irq not low");
    a_pulldown_cap: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        capturing |=> STRAP_PULLDOWN_O) else $error("pulldown missing");
    a_clk_4m: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (!capturing && rate_mode == RATE_4M && $rose(REFERENCE_CLOCK_OUTPUT_O))
        |-> ##3 $fell(REFERENCE_CLOCK_OUTPUT_O)) else $error("4 MHz half period");
    a_no_sel_ce: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        strb_s2.ce_n |-> !selected) else $error("selected without ce");

    // capture window ends once and never reopens before the next reset
    sequence s_capture_end;
        capturing ##1 !capturing;
    endsequence
    a_capture_closes: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_capture_end |=> !capturing) else $error("capture reopened");

    // pulldowns released once the straps are taken
    a_pulldown_off: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !capturing |=> !STRAP_PULLDOWN_O) else $error("pulldown stuck");

    // captured mode shown on the status output
    a_mode_shown: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !capturing |=> (PORT_MODE_O == $past(port_mode))) else $error("mode not shown");

    // no access decoded inside the capture window
    a_cap_no_select: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        capturing |-> !selected) else $error("select during capture");

    // synchronous slave strap leaves the memory port dead
    a_sync_no_select: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (port_mode == PORT_SYNC) |-> !selected) else $error("select in sync mode");

    // reserved strap leads to halt, then to the status flag
    sequence s_reserved_seen;
        !capturing && (port_mode == PORT_RESERVED);
    endsequence
    a_reserved_halts: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_reserved_seen |=> (state == ST_HALT) ##1 HALTED_O) else $error("reserved not halted");

    // halted device keeps its interrupt line quiet
    a_halt_irq_quiet: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        HALTED_O |-> HOST_IRQ_N_O) else $error("irq while halted");

    // interrupt released when the request goes away
    a_irq_release: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !irq_s2 |=> HOST_IRQ_N_O) else $error("irq not released");

    // illegal access never stores
    a_no_store_bad: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (acc == ACC_ILLEGAL) |-> !do_write) else $error("illegal stored");

    // one store per strobe assertion
    a_single_write: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == ST_DONE) |-> !do_write) else $error("burst write");

    // word write fills both bytes
    a_word_both: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (do_write && strb_s2.bsel_n == SEL_WORD) |-> (wr_even && wr_odd)) else $error("word lanes");

    // even byte write touches the high half only
    a_even_only: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (do_write && strb_s2.bsel_n == SEL_EVEN) |-> (wr_even && !wr_odd)) else $error("even lanes");

    // odd byte write touches the low half only
    a_odd_only: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (do_write && strb_s2.bsel_n == SEL_ODD) |-> (!wr_even && wr_odd)) else $error("odd lanes");

    // read direction follows the write strobe
    a_read_dir: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        rd_ok |-> (strb_s2.we_n && !strb_s2.oe_n)) else $error("read direction");

    // both byte selects high on a write is flagged
    a_bsel_flag: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (bad_sel && state != ST_HALT) |=> ILLEGAL_O) else $error("bad select missed");

    // drive ends one cycle after the read goes away
    sequence s_read_end;
        DATA_OE_O ##1 !rd_ok;
    endsequence
    a_oe_release: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_read_end |=> !DATA_OE_O) else $error("drive held");

    // fast rates toggle the clock output every cycle
    sequence s_fast_run;
        !capturing && (rate_mode == RATE_10M || rate_mode == RATE_40M);
    endsequence
    a_clk_fast: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        s_fast_run |=> (REFERENCE_CLOCK_OUTPUT_O != $past(REFERENCE_CLOCK_OUTPUT_O))) else $error("fast rate");

    // halted device flags nothing
    a_halt_no_flag: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        HALTED_O |-> !ILLEGAL_O) else $error("flag while halted");

    // halted device selects nothing
    a_halt_no_sel: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (state == ST_HALT) |-> !selected) else $error("select while halted");

    // stores only happen on the memory port
    a_write_async: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        do_write |-> port_async) else $error("store off port");

    // reads need chip enable
    a_read_ce: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        rd_ok |-> !strb_s2.ce_n) else $error("read without ce");

    // no drive right after a write cycle
    a_write_no_drive: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        wr_cyc |=> !DATA_OE_O) else $error("drive on write");

    // both strobes low never counts as a read
    a_bad_no_read: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        bad_cyc |-> !rd_ok) else $error("illegal read");

    // 4 MHz low half period
    a_clk_4m_low: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (!capturing && rate_mode == RATE_4M && $fell(REFERENCE_CLOCK_OUTPUT_O))
        |-> ##3 $rose(REFERENCE_CLOCK_OUTPUT_O)) else $error("4 MHz low half");

    // halted device stores nothing
    a_halt_no_write: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        HALTED_O |-> !do_write) else $error("store while halted");
endmodule : strap_host_port

// ===== tb/host_mcu_model.sv
// host microcontroller model issuing single asynchronous memory cycles
`timescale 1ns/10ps
module host_mcu_model
    import strap_host_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              ext_run_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    input  wire logic              rdata_oe_i,
    input  wire logic              illegal_i,
    output strobes_t               strb_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      wdata_o,
    output logic                   ext_clk_o
);
    // idle bus at time zero
    initial begin
        strb_o    = 5'h1F;
        addr_o    = '0;
        wdata_o   = 16'h5A5A;
        ext_clk_o = 1'h0;
    end

    // host clock runs only when selected, otherwise held low, never floating
    always @(posedge clk_i) ext_clk_o <= ext_run_i ? ~ext_clk_o : 1'h0;

    // one transfer: strobes held until the answer or a bounded wait, then released
    task automatic xfer(input logic wr, input logic rd, input logic [1:0] bs, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic drv,
                        output logic ill);
        q   = '0;
        drv = 1'h0;
        ill = 1'h0;
        @(posedge clk_i);
        strb_o  <= {1'h0, ~wr, ~rd, bs};
        addr_o  <= a;
        wdata_o <= d;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            #1;
            ill = ill | (illegal_i === 1'h1);
            if (rdata_oe_i === 1'h1) begin
                drv = 1'h1;
                q   = rdata_i;
                break;
            end
        end
        @(posedge clk_i);
        strb_o  <= 5'h1F;
        wdata_o <= ~d;    // released data must not keep its last value
        repeat (8) @(posedge clk_i);
    endtask : xfer
endmodule : host_mcu_model

// ===== tb/strap_host_port_tb.sv
// self-checking bench for the strap-select asynchronous host port
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module strap_host_port_tb;
    import strap_host_pkg::*;
    logic              clk, resetn, irq_req, ext_run, prev, drv, ill;
    logic [1:0]        port_strap, rate_strap, bs;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d, q, exp, rdata;
    logic              rdata_oe, illegal, ext_clk;
    strobes_t          strb;
    int                num_errors, n_compared, seed, cnt;
    logic [ADDR_W-1:0] a_bus;
    logic [DATA_W-1:0] d_bus;

    strap_host_port i_strap_host_port (.CLK_I(clk), .RESETN_I(resetn), .EXT_HOST_CLK_I(ext_clk),
        .PORT_STRAP_I(port_strap), .RATE_STRAP_I(rate_strap), .CE_N_I(strb.ce_n), .WE_N_I(strb.we_n),
        .OE_N_I(strb.oe_n), .BYTE_LANE_SELECT_N_I(strb.bsel_n), .ADDR_I(a_bus), .DATA_I(d_bus),
        .IRQ_REQ_I(irq_req), .DATA_O(rdata), .DATA_OE_O(rdata_oe), .STRAP_PULLDOWN_O(),
        .REFERENCE_CLOCK_OUTPUT_O(), .HOST_IRQ_N_O(), .PORT_MODE_O(), .HALTED_O(), .ILLEGAL_O(illegal));
    host_mcu_model i_host_mcu_model (.clk_i(clk), .ext_run_i(ext_run), .rdata_i(rdata), .rdata_oe_i(rdata_oe),
        .illegal_i(illegal), .strb_o(strb), .addr_o(a_bus), .wdata_o(d_bus), .ext_clk_o(ext_clk));

    // clock at 25 MHz
    always #20 clk = ~clk;

    // expected toggles of the clock output over 60 cycles
    function automatic int exp_tog(input int r);
        if (r == 3) return 0;
        return 60 / (r == 0 ? HALF_4M : (r == 1 ? HALF_10M : HALF_40M));
    endfunction : exp_tog

    // word after a write with the given byte selects
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] s);
        case (s)
            SEL_WORD: return nw;
            SEL_EVEN: return {nw[15:8], old[7:0]};
            SEL_ODD:  return {old[15:8], nw[7:0]};
            default:  return old;
        endcase
    endfunction : merge

    task automatic wrap_up();
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // reset with given straps held across release
    task automatic do_reset(input logic [1:0] ps, input logic [1:0] rs);
        @(posedge clk);
        resetn     <= 1'h0;
        port_strap <= ps;
        rate_strap <= rs;
        repeat (12) @(posedge clk);
        #1;
        `CHK(i_strap_host_port.HOST_IRQ_N_O, 1'h1)
        `CHK(i_strap_host_port.STRAP_PULLDOWN_O, 1'h1)
        @(posedge clk);
        resetn <= 1'h1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(i_strap_host_port.STRAP_PULLDOWN_O, 1'h0)
        `CHK(i_strap_host_port.PORT_MODE_O, ps)
        `CHK(i_strap_host_port.HALTED_O, (ps == PORT_RESERVED))
    endtask : do_reset

    // watchdog
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    initial begin
        clk = 1'h0; resetn = 1'h0; irq_req = 1'h0; ext_run = 1'h0;
        port_strap = 2'h1; rate_strap = 2'h0; seed = 88258; num_errors = 0; n_compared = 0;
        // clock output rate for every rate code
        for (int r = 0; r < 4; r++) begin
            do_reset(2'h1, 2'(r));
            cnt  = 0;
            prev = i_strap_host_port.REFERENCE_CLOCK_OUTPUT_O;
            repeat (60) begin
                @(posedge clk);
                #1;
                cnt += int'(i_strap_host_port.REFERENCE_CLOCK_OUTPUT_O !== prev);
                prev = i_strap_host_port.REFERENCE_CLOCK_OUTPUT_O;
            end
            `CHK((cnt >= exp_tog(r) - 1) && (cnt <= exp_tog(r) + 1), 1'h1)
            if (r == 3) `CHK(prev, 1'h0)
        end
        // every port strap code, each one recovered by a fresh reset
        for (int p = 0; p < 4; p++) begin
            ext_run <= (p == 3);
            do_reset(2'(p), 2'h0);
            i_host_mcu_model.xfer(1'h1, 1'h0, SEL_WORD, 12'h005, 16'hC3A1, q, drv, ill);
            i_host_mcu_model.xfer(1'h0, 1'h1, SEL_WORD, 12'h005, 16'h0000, q, drv, ill);
            `CHK(drv, (p == 1 || p == 3))
            if (drv) `CHK(q, 16'hC3A1)
        end
        ext_run <= 1'h0;
        do_reset(2'h1, 2'h0);
        // strap change after reset plus interrupt level
        port_strap <= 2'h2;
        irq_req    <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        `CHK(i_strap_host_port.PORT_MODE_O, PORT_ASYNC_MAIN)
        `CHK(i_strap_host_port.HOST_IRQ_N_O, 1'h0)
        @(posedge clk);
        irq_req <= 1'h0;
        repeat (4) @(posedge clk);
        #1;
        `CHK(i_strap_host_port.HOST_IRQ_N_O, 1'h1)
        // random word and byte writes with read-back, corners first
        for (int k = 0; k < 40; k++) begin
            a = (k == 0) ? 12'h000 : (k == 1) ? 12'hFFF : 12'($random(seed));
            d = 16'($random(seed));
            i_host_mcu_model.xfer(1'h1, 1'h0, SEL_WORD, a, d, q, drv, ill);
            `CHK(drv, 1'h0)
            exp = d;
            bs  = 2'($random(seed));
            d   = 16'($random(seed));
            i_host_mcu_model.xfer(1'h1, 1'h0, bs, a, d, q, drv, ill);
            `CHK(ill, (bs == 2'h3))
            exp = merge(exp, d, bs);
            if (k == 5) begin
                i_host_mcu_model.xfer(1'h1, 1'h1, SEL_WORD, a, 16'hFFFF, q, drv, ill);
                `CHK(ill, 1'h1)
                `CHK(drv, 1'h0)
            end
            i_host_mcu_model.xfer(1'h0, 1'h1, bs, a, 16'h0000, q, drv, ill);
            `CHK(drv, 1'h1)
            `CHK(q, exp)
        end
        wrap_up();
    end
endmodule : strap_host_port_tb
